// *** common/apo_pkg.sv ***
// accumulator pulse output: shared constants and types
// assumes a single 250 MHz system clock; module clock is an enable pulse
//
// Behaviour
// (RL1) In fixed duty mode the output inverts on each accumulator overflow, halving the rate.
// (RL2) A zero pulse-mode select bit selects fixed duty mode.
// (RL3) In pulse mode each overflow makes the output active for one or more module clocks.
// (RL4) In pulse mode the output goes active on the first module clock after the overflow.
// (RL5) The polarity bit maps active/inactive levels as the last stage of the output path.
// (RL6) A one pulse-mode select bit selects pulse frequency mode.
// (RL7) The three-bit pulse width field picks the active length in module clock periods.
// (RL8) When the pulse width exceeds the overflow interval the output does not toggle.
// (RL9) An output transition caused by a polarity change raises the interrupt flag too; here only with module and overflow irq enables set.
// (RL10) Each accumulator overflow sets the overflow interrupt flag.
// (RL11) An interrupt is delivered only with module, module irq, peripheral and global enables set.
// (RL12) Software clears the flag; hardware never clears it by itself.
// (RL13) Any reset clears every register of the module to zero.
// (RL14) The module keeps running in sleep while its clock source is active.
// (RL15) With the internal fast oscillator selected and enabled it stays on through sleep.
// (RL16) Each module clock adds the increment, and a carry out of the top bit is an overflow.
package apo_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int unsigned APO_ACC_W   = 20;
  localparam int unsigned APO_PWS_W   = 3;
  localparam int unsigned APO_DIV_W   = 8;
  localparam int unsigned APO_CNT_W   = 8;
  localparam logic        APO_LVL_RST = 1'b0;
  localparam logic [APO_CNT_W-1:0] APO_CNT_ONE = {{(APO_CNT_W-1){1'b0}}, 1'b1};

  // ==========================================================================
  // output state machine
  typedef enum logic [1:0] {
    APO_IDLE,
    APO_ACTIVE
  } apo_state_t;

endpackage : apo_pkg

// *** hw/apo_accum.sv ***
// accumulator pulse output: phase accumulator with overflow carry
// assumes a one-cycle module clock enable from the parent
`timescale 1ns/1ps

module apo_accum
  import apo_pkg::*;
#(
  parameter int unsigned ACC_W = APO_ACC_W
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic [ACC_W-1:0] increment,
  // result
  output logic      [ACC_W-1:0] acc_value,
  output logic                  overflow
);

  logic [ACC_W:0] sum;

  assign sum = {1'b0, acc_value} + {1'b0, increment};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_value <= '0;                                     // RL13
      overflow  <= 1'b0;
    end
    else
    begin
      overflow <= 1'b0;
      if (tick && run)
      begin
        acc_value <= sum[ACC_W-1:0];                       // RL16
        overflow  <= sum[ACC_W];                           // RL16
      end
    end
  end

endmodule : apo_accum

// *** hw/apo_top.sv ***
// accumulator pulse output: top level with mode, polarity and interrupt logic
// assumes synchronous control inputs; module clock comes from a divider enable
`timescale 1ns/1ps

module apo_top
  import apo_pkg::*;
#(
  parameter int unsigned ACC_W = APO_ACC_W,
  parameter int unsigned DIV_W = APO_DIV_W
)
(
  // clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             RST_N,
  // module clock source: divide ratio minus one, and source alive
  input  wire logic [DIV_W-1:0] MODULE_CLK_DIV,
  input  wire logic             CLK_SOURCE_ACTIVE,
  input  wire logic             FAST_OSC_SELECT,
  input  wire logic             SLEEP,
  // control bits
  input  wire logic             MODULE_ENABLE,
  input  wire logic             PULSE_MODE_SELECT,
  input  wire logic             OUTPUT_POLARITY,
  input  wire logic [2:0]       PULSE_WIDTH_SELECT,
  input  wire logic [ACC_W-1:0] INCREMENT,
  // interrupt enables and flag clear
  input  wire logic             OVERFLOW_IRQ_ENABLE,
  input  wire logic             PERIPHERAL_IRQ_ENABLE,
  input  wire logic             GLOBAL_IRQ_ENABLE,
  input  wire logic             OVERFLOW_IRQ_FLAG_CLR,
  // results
  output logic                  OSCILLATOR_OUTPUT,
  output logic                  OVERFLOW_IRQ_FLAG,
  output logic                  IRQ,
  output logic                  FAST_OSC_KEEP_ON,
  output logic      [ACC_W-1:0] ACC_VALUE
);

  // ==========================================================================
  // module clock divider
  logic [DIV_W-1:0] div_reg;
  logic             tick;
  logic             run;
  logic             div_last;

  // sleep is deliberately not a term: the module ignores the system clock state
  assign run      = MODULE_ENABLE && CLK_SOURCE_ACTIVE;             // RL14
  // divider restarts while stopped, so the first tick after enable is a full period
  assign div_last = (div_reg == MODULE_CLK_DIV);
  assign tick     = run && div_last;
  assign FAST_OSC_KEEP_ON = MODULE_ENABLE && FAST_OSC_SELECT;      // RL15

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      div_reg <= '0;
    else if (!run || tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  // ==========================================================================
  // accumulator
  logic accumulator_overflow;

  apo_accum #(
    .ACC_W     (ACC_W)
  ) u_accum (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .tick      (tick),
    .run       (run),
    .increment (INCREMENT),
    .acc_value (ACC_VALUE),
    .overflow  (accumulator_overflow)
  );

  // ==========================================================================
  // output generation, before polarity
  apo_state_t             state_reg;
  apo_state_t             state_next;
  logic                   level_reg;
  logic                   level_next;
  logic [APO_CNT_W-1:0]   width_reg;
  logic [APO_CNT_W-1:0]   width_next;
  logic [APO_CNT_W-1:0]   width_len;
  logic                   pend_reg;
  logic                   pend_next;
  logic                   pulse_start;
  logic                   width_done;

  // width field gives 2^n module clock periods
  assign width_len   = APO_CNT_ONE << PULSE_WIDTH_SELECT;           // RL7
  // the pulse waits for the first module clock after the overflow
  assign pulse_start = tick && pend_reg;                            // RL4
  // last module clock of the pulse
  assign width_done  = tick && (width_reg == '0);

  always_comb
  begin
    state_next = state_reg;
    level_next = level_reg;
    width_next = width_reg;
    pend_next  = pend_reg || accumulator_overflow;
    if (!PULSE_MODE_SELECT)                                         // RL2
    begin
      state_next = APO_IDLE;
      pend_next  = 1'b0;
      if (accumulator_overflow)
        level_next = ~level_reg;                                    // RL1
    end
    else                                                            // RL6
    begin
      unique case (state_reg)
        APO_IDLE:
        begin
          level_next = APO_LVL_RST;
          if (pulse_start)                                          // RL4
          begin
            state_next = APO_ACTIVE;
            level_next = 1'b1;                                      // RL3
            width_next = width_len - APO_CNT_ONE;
            pend_next  = accumulator_overflow;
          end
        end
        APO_ACTIVE:
        begin
          // overflows inside the pulse are swallowed, so it never re-toggles
          pend_next = 1'b0;                                         // RL8
          if (width_done)
          begin
            state_next = APO_IDLE;
            level_next = APO_LVL_RST;                               // RL3
          end
          else if (tick)
            width_next = width_reg - APO_CNT_ONE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= APO_IDLE;                                        // RL13
      level_reg <= APO_LVL_RST;
      width_reg <= '0;
      pend_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      level_reg <= level_next;
      width_reg <= width_next;
      pend_reg  <= pend_next;
    end
  end

  // ==========================================================================
  // polarity stage, last in the output path
  logic out_next;
  logic out_reg;
  logic pol_reg;
  logic pol_changed;
  logic out_changes;

  assign out_next    = level_next ^ OUTPUT_POLARITY;                // RL5
  assign out_changes = (out_next != out_reg);
  // previous polarity held in a flop, so the compare stays plain logic
  assign pol_changed = (OUTPUT_POLARITY != pol_reg);

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      out_reg <= 1'b0;                                              // RL13
    else
      out_reg <= out_next;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pol_reg <= 1'b0;
    else
      pol_reg <= OUTPUT_POLARITY;
  end

  // ==========================================================================
  // interrupt flag and request gate
  logic flag_reg;
  logic ovf_set;
  logic pol_set;
  logic flag_set;
  logic irq_gate;

  // every overflow flags, in either mode
  assign ovf_set  = accumulator_overflow;                           // RL10
  // a polarity flip only counts when it really moves the output
  assign pol_set  = MODULE_ENABLE && OVERFLOW_IRQ_ENABLE
                    && pol_changed && out_changes;                  // RL9
  assign flag_set = ovf_set || pol_set;
  assign irq_gate = MODULE_ENABLE && OVERFLOW_IRQ_ENABLE
                    && PERIPHERAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE;  // RL11

  // set beats a simultaneous software clear
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      flag_reg <= 1'b0;
    else if (flag_set)
      flag_reg <= 1'b1;
    else if (OVERFLOW_IRQ_FLAG_CLR)
      flag_reg <= 1'b0;                                             // RL12
  end

  // ==========================================================================
  // outputs
  assign OSCILLATOR_OUTPUT = out_reg;
  assign OVERFLOW_IRQ_FLAG = flag_reg;
  assign IRQ               = flag_reg && irq_gate;

endmodule : apo_top

// *** test/apo_checker.sv ***
// accumulator pulse output: port-level assertions
// assumes apo_top ports only; bound to it at the foot of this file
`timescale 1ns/1ps

module apo_checker #(
  parameter int unsigned ACC_W = 20,
  parameter int unsigned DIV_W = 8
)
(
  // clock, reset and controls
  input wire logic             SYS_CLK, RST_N, CLK_SOURCE_ACTIVE, FAST_OSC_SELECT, SLEEP,
  input wire logic [DIV_W-1:0] MODULE_CLK_DIV,
  input wire logic             MODULE_ENABLE, PULSE_MODE_SELECT, OUTPUT_POLARITY,
  input wire logic [2:0]       PULSE_WIDTH_SELECT,
  input wire logic [ACC_W-1:0] INCREMENT,
  input wire logic             OVERFLOW_IRQ_ENABLE, PERIPHERAL_IRQ_ENABLE, GLOBAL_IRQ_ENABLE,
  input wire logic             OVERFLOW_IRQ_FLAG_CLR,
  // results
  input wire logic             OSCILLATOR_OUTPUT, OVERFLOW_IRQ_FLAG, IRQ, FAST_OSC_KEEP_ON,
  input wire logic [ACC_W-1:0] ACC_VALUE
);
  // ==========================================================================
  // wrap must match the sum, so a cleared accumulator is not taken for one
  logic [ACC_W-1:0] prev_acc_reg;
  logic [ACC_W-1:0] prev_inc_reg;
  logic             wrap;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prev_acc_reg <= '0;
      prev_inc_reg <= '0;
    end
    else
    begin
      prev_acc_reg <= ACC_VALUE;
      prev_inc_reg <= INCREMENT;
    end
  end
  assign wrap = (ACC_VALUE < prev_acc_reg) && (ACC_VALUE == prev_acc_reg + prev_inc_reg);

  // ==========================================================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  chk_acc_adds : assert property ($changed(ACC_VALUE) |->
    ACC_VALUE == $past(ACC_VALUE) + $past(INCREMENT)) else $error("accumulator step wrong");
  chk_src_freeze : assert property (!CLK_SOURCE_ACTIVE |=> $stable(ACC_VALUE))
    else $error("accumulator moved without clock source");
  chk_fdc_toggle : assert property (wrap && !PULSE_MODE_SELECT && $stable(OUTPUT_POLARITY)
    |-> ##[1:2] $changed(OSCILLATOR_OUTPUT)) else $error("no toggle on overflow");
  chk_pf_start : assert property (wrap && PULSE_MODE_SELECT && $stable(OUTPUT_POLARITY)
    |-> ##[1:3] OSCILLATOR_OUTPUT != OUTPUT_POLARITY) else $error("pulse not active");
  chk_pol_flip : assert property ($changed(OUTPUT_POLARITY) && INCREMENT == '0
    |-> ##[1:2] $changed(OSCILLATOR_OUTPUT)) else $error("polarity not applied");
  chk_pol_flag : assert property ($changed(OUTPUT_POLARITY) && INCREMENT == '0 &&
    MODULE_ENABLE && OVERFLOW_IRQ_ENABLE |-> ##[1:3] OVERFLOW_IRQ_FLAG) else $error("no flag");
  chk_flag_set : assert property (wrap |-> ##[1:2] OVERFLOW_IRQ_FLAG)
    else $error("flag not set by overflow");
  chk_flag_sticky : assert property (OVERFLOW_IRQ_FLAG && !OVERFLOW_IRQ_FLAG_CLR |=>
    OVERFLOW_IRQ_FLAG) else $error("flag dropped by itself");
  chk_irq_gate : assert property (IRQ == (OVERFLOW_IRQ_FLAG && MODULE_ENABLE &&
    OVERFLOW_IRQ_ENABLE && PERIPHERAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE)) else $error("irq gate");
  chk_keep_on : assert property (FAST_OSC_KEEP_ON == (MODULE_ENABLE && FAST_OSC_SELECT))
    else $error("fast oscillator hold wrong");
  chk_reset_zero : assert property (disable iff (1'b0) !RST_N ##1 !RST_N |->
    ACC_VALUE == '0 && !OVERFLOW_IRQ_FLAG && !OSCILLATOR_OUTPUT) else $error("reset not clear");
endmodule : apo_checker

bind apo_top apo_checker #(.ACC_W(ACC_W), .DIV_W(DIV_W)) u_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_SOURCE_ACTIVE(CLK_SOURCE_ACTIVE), .SLEEP(SLEEP),
  .FAST_OSC_SELECT(FAST_OSC_SELECT), .MODULE_CLK_DIV(MODULE_CLK_DIV),
  .MODULE_ENABLE(MODULE_ENABLE), .PULSE_MODE_SELECT(PULSE_MODE_SELECT),
  .OUTPUT_POLARITY(OUTPUT_POLARITY), .PULSE_WIDTH_SELECT(PULSE_WIDTH_SELECT),
  .INCREMENT(INCREMENT), .OVERFLOW_IRQ_ENABLE(OVERFLOW_IRQ_ENABLE),
  .PERIPHERAL_IRQ_ENABLE(PERIPHERAL_IRQ_ENABLE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .OVERFLOW_IRQ_FLAG_CLR(OVERFLOW_IRQ_FLAG_CLR), .OSCILLATOR_OUTPUT(OSCILLATOR_OUTPUT),
  .OVERFLOW_IRQ_FLAG(OVERFLOW_IRQ_FLAG), .IRQ(IRQ), .FAST_OSC_KEEP_ON(FAST_OSC_KEEP_ON),
  .ACC_VALUE(ACC_VALUE));

// *** test/apo_tb_top.sv ***
// accumulator pulse output: self-checking bench
// assumes apo_top with default widths; the bench drives every port itself
`timescale 1ns/1ps

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module apo_tb_top;
  // ==========================================================================
  // stimulus and observation
  logic        clk = 1'b0, rst_n, src = 1'b1, fos = 1'b0, slp = 1'b0, men = 1'b1;
  logic        pms = 1'b0, pol = 1'b0, oie = 1'b0, pie = 1'b0, global_irq_enable = 1'b0, clr = 1'b0;
  logic [7:0]  div = 8'h00;
  logic [2:0]  pws = 3'h0;
  logic [19:0] inc = 20'h00000;
  logic [19:0] acc;
  logic        out, flag, irq, keep;
  int          fail_count = 0, samples_checked = 0, seed = 68394, n;
  always #2 clk = ~clk;

  apo_top dut (.SYS_CLK(clk), .RST_N(rst_n), .MODULE_CLK_DIV(div), .CLK_SOURCE_ACTIVE(src),
    .FAST_OSC_SELECT(fos), .SLEEP(slp), .MODULE_ENABLE(men), .PULSE_MODE_SELECT(pms),
    .OUTPUT_POLARITY(pol), .PULSE_WIDTH_SELECT(pws), .INCREMENT(inc),
    .OVERFLOW_IRQ_ENABLE(oie), .PERIPHERAL_IRQ_ENABLE(pie), .GLOBAL_IRQ_ENABLE(global_irq_enable),
    .OVERFLOW_IRQ_FLAG_CLR(clr), .OSCILLATOR_OUTPUT(out), .OVERFLOW_IRQ_FLAG(flag),
    .IRQ(irq), .FAST_OSC_KEEP_ON(keep), .ACC_VALUE(acc));

  // ==========================================================================
  // helpers
  function automatic int exp_width(input int w);
    return 1 << w;
  endfunction : exp_width
  function automatic logic exp_irq(input logic f, input logic [3:0] e);
    return f & (&e);
  endfunction : exp_irq
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // bounded: a pulse that never comes or never ends is a mismatch
  task automatic pulse_len(output int len);
    int wait_cnt;
    len = 0;
    wait_cnt = 0;
    while (wait_cnt < 600 && out === pol)
    begin
      wait_cnt++;
      cyc(1);
    end
    while (out !== pol && len < 300)
    begin
      len++;
      cyc(1);
    end
    if (wait_cnt == 600 || len == 300)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask : pulse_len
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // scenarios
  initial
  begin
    // starts unknown, so this is a real falling edge for the async reset
    rst_n <= 1'b0;
    cyc(10);
    `CHK("acc_reset", 20'h00000, acc)
    @(posedge clk) rst_n <= 1'b1;
    // overflow every second tick, while asleep
    @(posedge clk) inc <= 20'h80000;
    slp <= 1'b1;
    cyc(20);
    n = 0;
    repeat (8)
    begin
      cyc(1);
      n += out;
    end
    `CHK("fdc_duty", 4, n)
    `CHK("flag_set", 1'b1, flag)
    @(posedge clk) inc <= 20'h00000;
    cyc(4);
    for (int p = 0; p < 2; p++)
      for (int w = 0; w < 8; w++)
      begin
        @(posedge clk) inc <= 20'h01000;
        pms <= 1'b1;
        pol <= p[0];
        pws <= w[2:0];
        pulse_len(n);
        pulse_len(n);
        `CHK("pf_width", exp_width(w), n)
        `CHK("pf_idle", p[0], out)
      end
    // overflow every fourth tick inside an eight-tick pulse
    @(posedge clk) inc <= 20'h40000;
    pws <= 3'h3;
    pulse_len(n);
    pulse_len(n);
    `CHK("pf_swallow", exp_width(3), n)
    @(posedge clk) inc <= 20'h00000;
    cyc(4);
    @(posedge clk) pms <= 1'b0;
    clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    cyc(3);
    `CHK("flag_clear", 1'b0, flag)
    @(posedge clk) oie <= 1'b1;
    pol <= ~pol;
    cyc(4);
    `CHK("pol_flag", 1'b1, flag)
    for (int e = 0; e < 16; e++)
    begin
      @(posedge clk) {men, oie, pie, global_irq_enable} <= e[3:0];
      cyc(1);
      `CHK("irq", exp_irq(1'b1, e[3:0]), irq)
    end
    @(posedge clk) men <= 1'b1;
    repeat (200)
    begin
      @(posedge clk) div <= 8'($random(seed) & 3);
      inc <= 20'($random(seed));
      src <= ($random(seed) & 7) != 0;
      fos <= 1'($random(seed));
      slp <= 1'($random(seed));
      clr <= ($random(seed) & 15) == 0;
      cyc(1);
      `CHK("keep_on", men & fos, keep)
      cyc(8);
    end
    @(posedge clk) rst_n <= 1'b0;
    cyc(2);
    `CHK("acc_mid_reset", 20'h00000, acc)
    `CHK("flag_mid_reset", 1'b0, flag)
    @(posedge clk) rst_n <= 1'b1;
    cyc(5);
    report_and_stop();
  end

  initial
  begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule : apo_tb_top
